// ===== src/usb_common_regs.sv
// Common control and status registers of a USB 2.0 function controller.
// Function
// - Power bit 6 enables the data lines; cleared leaves them tri-stated.
// - Power bit 5 requests high-speed negotiation during a bus reset.
// - Power bit 4 reads one after successful high-speed negotiation.
// - Power bit 3 reads one while reset signalling is on the bus.
// - While power bit 2 is set, resume signalling is driven.
// - Power bit 1 flags suspend; cleared by event-flag read or resume set.
// - Power bit 0 lets the active-low suspend line assert in suspend.
// - Power bit 7 reads zero; power register resets to 20h.
// - Address write sets pending bit 7 until the address takes effect.
// - Bits 6:0 hold the bus address applied at end of transfer.
// - IN flags: endpoint 2 bit 2, endpoint 1 bit 1, control bit 0.
// - Reading the IN flag register returns flags then clears them.
// - OUT flags at bits 2 and 1 clear when read; bit 0 reserved.
// - IN enable register bits 2:0, reset 07h.
// - OUT enable register bits 2:1, reset 06h.
// - Bus event enables for frame start, reset, resume, suspend, reset 06h.
// - Bus event flags at bits 3:0 clear when the register is read.
// - Last received 11-bit frame number split high and low, reset zero.
// - Interrupt on enabled IN or OUT endpoint events and on enabled bus events.
`timescale 1ns/1ps
module usb_common_regs #(
  parameter int WAKE_MIN = usb_common_pkg::WAKE_MIN_CYCLES, // Shortest resume, cycles.
  parameter int WAKE_MAX = usb_common_pkg::WAKE_MAX_CYCLES // Longest resume, cycles.
) (
  input wire logic clk, // System clock, 250 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; while low all state holds except the resume length counter, which still clears once resume drive is off.
  input wire logic [3:0] reg_addr, // CPU register offset.
  input wire logic reg_wr, // CPU write strobe.
  input wire logic reg_rd, // CPU read strobe.
  input wire logic [7:0] reg_wdata, // CPU write data.
  output logic [7:0] reg_rdata, // CPU read data, one cycle after the strobe.
  input wire logic bus_reset_seen, // Level: reset signalling on the bus.
  input wire logic hs_handshake_ok, // Pulse: high-speed chirp succeeded.
  input wire logic sleep_detect, // Pulse: bus idle long enough to suspend.
  input wire logic wake_detect, // Pulse: resume seen on the bus.
  input wire logic frame_start, // Pulse: start-of-frame token received.
  input wire logic [10:0] frame_count, // Frame number with frame_start.
  input wire logic transfer_end, // Pulse: current transfer finished.
  input wire logic [2:0] in_done, // Pulses: IN endpoint 2..0 events.
  input wire logic [2:1] out_done, // Pulses: OUT endpoint 2..1 events.
  output logic line_enable, // Data line drivers enabled.
  output logic fast_negotiate_request, // Try high speed at next bus reset.
  output logic wake_signal_drive, // Drive resume signalling.
  output logic sleep_line_n, // UTMI suspend output, active low.
  output logic [6:0] device_bus_address, // Address the device answers to.
  output logic cpu_irq // Interrupt request to the CPU.
);
  typedef struct packed {
    logic [7:0] rdata;
    logic line_en;
    logic fast_req;
    logic hs_active;
    logic bus_rst;
    logic wake;
    logic sleep;
    logic sleep_en;
    logic sleep_n;
    logic pending;
    logic [6:0] staged;
    logic [6:0] addr;
    logic [10:0] frame;
    logic [2:0] in_mask;
    logic [2:1] out_mask;
    logic [3:0] evt_mask;
    logic irq;
  } regs_s;
  regs_s st_q, st_d;

  logic wr_power, wr_addr, rd_in, rd_out, rd_evt;
  logic [2:0] in_flags;
  logic [2:0] out_flags;
  logic [3:0] evt_flags;
  logic [3:0] evt_set;
  logic [2:0] out_set;

  // Strobes are taken only while the clock enable is high.
  assign wr_power = ce && reg_wr && (reg_addr == usb_common_pkg::OFS_POWER);
  assign wr_addr = ce && reg_wr && (reg_addr == usb_common_pkg::OFS_ADDR);
  assign rd_in = ce && reg_rd && (reg_addr == usb_common_pkg::OFS_IN_FLAGS);
  assign rd_out = ce && reg_rd && (reg_addr == usb_common_pkg::OFS_OUT_FLAGS);
  assign rd_evt = ce && reg_rd && (reg_addr == usb_common_pkg::OFS_EVT_FLAGS);

  // Bus events; the reset flag fires on the rising edge of reset signalling.
  assign evt_set = {frame_start, bus_reset_seen & ~st_q.bus_rst, wake_detect, sleep_detect};
  assign out_set = {out_done, 1'b0};

  // Flag banks for IN, OUT and bus events; each read clears its own bank.
  irq_flag_bank #(.W(3)) u_in_flags (
    .clk(clk), .rst(rst), .ce(ce), .set(in_done), .clr(rd_in), .flags(in_flags)
  );
  irq_flag_bank #(.W(3)) u_out_flags (
    .clk(clk), .rst(rst), .ce(ce), .set(out_set), .clr(rd_out), .flags(out_flags)
  );
  irq_flag_bank #(.W(4)) u_evt_flags (
    .clk(clk), .rst(rst), .ce(ce), .set(evt_set), .clr(rd_evt), .flags(evt_flags)
  );

  // Next-state logic for control bits, address, frame number and read data.
  always_comb begin
    st_d = st_q;
    st_d.bus_rst = bus_reset_seen;
    // Speed result is dropped when a new bus reset starts, then set by the chirp.
    if (bus_reset_seen && !st_q.bus_rst) begin
      st_d.hs_active = 1'b0;
    end
    if (st_q.bus_rst && hs_handshake_ok && st_q.fast_req) begin
      st_d.hs_active = 1'b1;
    end
    if (wr_power) begin
      st_d.line_en = reg_wdata[usb_common_pkg::PWR_SOFT_ATTACH];
      st_d.fast_req = reg_wdata[usb_common_pkg::PWR_FAST_REQ];
      st_d.wake = reg_wdata[usb_common_pkg::PWR_WAKE];
      st_d.sleep_en = reg_wdata[usb_common_pkg::PWR_SLEEP_EN];
    end
    // Suspend state clears on event-flag read or resume request; entry wins.
    if (rd_evt || (wr_power && reg_wdata[usb_common_pkg::PWR_WAKE])) begin
      st_d.sleep = 1'b0;
    end
    if (sleep_detect) begin
      st_d.sleep = 1'b1;
    end
    st_d.sleep_n = ~(st_d.sleep & st_d.sleep_en);
    // New address waits in a staging register so the running transfer completes.
    if (transfer_end && st_q.pending) begin
      st_d.addr = st_q.staged;
      st_d.pending = 1'b0;
    end
    if (wr_addr) begin
      st_d.staged = reg_wdata[6:0];
      st_d.pending = 1'b1;
    end
    if (frame_start) begin
      st_d.frame = frame_count;
    end
    if (ce && reg_wr) begin
      unique case (reg_addr)
        usb_common_pkg::OFS_IN_MASK: st_d.in_mask = reg_wdata[2:0];
        usb_common_pkg::OFS_OUT_MASK: st_d.out_mask = reg_wdata[2:1];
        usb_common_pkg::OFS_EVT_MASK: st_d.evt_mask = reg_wdata[3:0];
        default: st_d.evt_mask = st_d.evt_mask;
      endcase
    end
    // Read data mux; reserved bits and unmapped offsets read zero.
    st_d.rdata = 8'h00;
    if (ce && reg_rd) begin
      unique case (reg_addr)
        usb_common_pkg::OFS_POWER: st_d.rdata = {1'b0, st_q.line_en, st_q.fast_req,
          st_q.hs_active, st_q.bus_rst, st_q.wake, st_q.sleep, st_q.sleep_en};
        usb_common_pkg::OFS_ADDR: st_d.rdata = {st_q.pending, st_q.staged};
        usb_common_pkg::OFS_IN_FLAGS: st_d.rdata = {5'h00, in_flags};
        usb_common_pkg::OFS_OUT_FLAGS: st_d.rdata = {5'h00, out_flags[2:1], 1'b0};
        usb_common_pkg::OFS_IN_MASK: st_d.rdata = {5'h00, st_q.in_mask};
        usb_common_pkg::OFS_OUT_MASK: st_d.rdata = {5'h00, st_q.out_mask, 1'b0};
        usb_common_pkg::OFS_EVT_MASK: st_d.rdata = {4'h0, st_q.evt_mask};
        usb_common_pkg::OFS_EVT_FLAGS: st_d.rdata = {4'h0, evt_flags};
        usb_common_pkg::OFS_FRAME_HIGH: st_d.rdata = {5'h00, st_q.frame[10:8]};
        usb_common_pkg::OFS_FRAME_LOW: st_d.rdata = st_q.frame[7:0];
        default: st_d.rdata = 8'h00;
      endcase
    end else begin
      st_d.rdata = st_q.rdata;
    end
    // The request follows the registered flags, so it drops a cycle after they clear, two cycles after a clearing read.
    st_d.irq = |(in_flags & st_q.in_mask) | |(out_flags[2:1] & st_q.out_mask)
      | |(evt_flags & st_q.evt_mask);
  end

  // Register the state copy; reset values come from the package.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.fast_req <= usb_common_pkg::RST_POWER[usb_common_pkg::PWR_FAST_REQ];
      st_q.sleep_n <= 1'b1;
      st_q.in_mask <= usb_common_pkg::RST_IN_MASK[2:0];
      st_q.out_mask <= usb_common_pkg::RST_OUT_MASK[2:1];
      st_q.evt_mask <= usb_common_pkg::RST_EVT_MASK[3:0];
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Every output comes straight from the state register.
  assign reg_rdata = st_q.rdata;
  assign line_enable = st_q.line_en;
  assign fast_negotiate_request = st_q.fast_req;
  assign wake_signal_drive = st_q.wake;
  assign sleep_line_n = st_q.sleep_n;
  assign device_bus_address = st_q.addr;
  assign cpu_irq = st_q.irq;

  // Resume length counter, read only by the cover below; it saturates to stay small.
  logic [31:0] wake_len_q;
  always_ff @(posedge clk) begin
    if (rst || !st_q.wake) begin
      wake_len_q <= '0;
    end else if (ce && (wake_len_q < 32'(WAKE_MAX))) begin
      wake_len_q <= wake_len_q + 32'd1;
    end
  end

  a_soft_attach_write: assert property (@(posedge clk) disable iff (rst)
    wr_power |=> (line_enable == $past(reg_wdata[6])))
    else $error("soft attach does not follow the write");
  a_hs_needs_request: assert property (@(posedge clk) disable iff (rst)
    $rose(st_q.hs_active) |-> $past(st_q.fast_req) && $past(st_q.bus_rst))
    else $error("high speed without request during reset");
  a_bus_reset_track: assert property (@(posedge clk) disable iff (rst)
    ce |=> (st_q.bus_rst == $past(bus_reset_seen)))
    else $error("bus reset bit does not track the bus");
  a_wake_drive_hold: assert property (@(posedge clk) disable iff (rst)
    wake_signal_drive && !wr_power |=> wake_signal_drive)
    else $error("resume drive stopped without a write");
  a_sleep_flag_clear: assert property (@(posedge clk) disable iff (rst)
    rd_evt && !sleep_detect |=> !st_q.sleep)
    else $error("suspend flag not cleared by read");
  a_sleep_line_gate: assert property (@(posedge clk) disable iff (rst)
    !st_q.sleep_en |-> sleep_line_n)
    else $error("suspend line asserted while gated");
  a_power_bit7_zero: assert property (@(posedge clk) disable iff (rst)
    ce && reg_rd && (reg_addr == usb_common_pkg::OFS_POWER) |=> !reg_rdata[7])
    else $error("power bit 7 reads one");
  a_addr_pending_set: assert property (@(posedge clk) disable iff (rst)
    wr_addr |=> st_q.pending ##0 (st_q.staged == $past(reg_wdata[6:0])))
    else $error("address write did not set pending");
  a_addr_apply_end: assert property (@(posedge clk) disable iff (rst)
    ce && transfer_end && st_q.pending && !wr_addr |=>
      (device_bus_address == $past(st_q.staged)) && !st_q.pending)
    else $error("address not applied at end of transfer");
  a_addr_hold_idle: assert property (@(posedge clk) disable iff (rst)
    !(ce && transfer_end) |=> $stable(device_bus_address))
    else $error("address changed outside a transfer end");
  a_frame_capture: assert property (@(posedge clk) disable iff (rst)
    ce && frame_start |=> (st_q.frame == $past(frame_count)))
    else $error("frame number not captured");
  a_irq_enabled_flag: assert property (@(posedge clk) disable iff (rst)
    ce && ((in_flags & st_q.in_mask) != 3'h0) |=> cpu_irq)
    else $error("enabled IN flag raised no interrupt");


  // The checks below watch each software-visible field against the strobe that owns it.
  // They are written against registered state so a glitch on a strobe cannot satisfy them.

  // High-speed request follows the power write.
  a_fast_req_write: assert property (@(posedge clk) disable iff (rst)
    wr_power |=> (fast_negotiate_request == $past(reg_wdata[5])))
    else $error("high speed request does not follow the write");

  // Soft attach moves only on a power write.
  a_line_en_hold: assert property (@(posedge clk) disable iff (rst)
    !wr_power |=> $stable(line_enable))
    else $error("soft attach changed without a write");

  // A new bus reset drops the previous speed result.
  a_hs_cleared_reset: assert property (@(posedge clk) disable iff (rst)
    ce && bus_reset_seen && !st_q.bus_rst |=> !st_q.hs_active)
    else $error("speed result kept across a new bus reset");

  // Resume drive follows the power write.
  a_wake_write: assert property (@(posedge clk) disable iff (rst)
    wr_power |=> (wake_signal_drive == $past(reg_wdata[2])))
    else $error("resume drive does not follow the write");

  // Suspend entry sets the flag, even against a clearing read.
  a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
    ce && sleep_detect |=> st_q.sleep)
    else $error("suspend entry not flagged");

  // Setting the resume bit clears the suspend flag.
  a_sleep_wake_clear: assert property (@(posedge clk) disable iff (rst)
    wr_power && reg_wdata[2] && !sleep_detect |=> !st_q.sleep)
    else $error("suspend flag not cleared by resume request");

  // With the gate open, suspend drives the line low.
  a_sleep_line_low: assert property (@(posedge clk) disable iff (rst)
    st_q.sleep && st_q.sleep_en |-> !sleep_line_n)
    else $error("suspend line not asserted in suspend");

  // IN flag read returns the flags as they stood before the clear.
  a_in_read_data: assert property (@(posedge clk) disable iff (rst)
    rd_in |=> (reg_rdata == {5'h00, $past(in_flags)}))
    else $error("IN flag read returned wrong data");

  // OUT flag read keeps reserved bits at zero.
  a_out_read_data: assert property (@(posedge clk) disable iff (rst)
    rd_out |=> (reg_rdata[7:3] == 5'h00) && !reg_rdata[0])
    else $error("OUT flag read shows reserved bits");

  // Bus event read returns the flags as they stood before the clear.
  a_evt_read_data: assert property (@(posedge clk) disable iff (rst)
    rd_evt |=> (reg_rdata == {4'h0, $past(evt_flags)}))
    else $error("bus event read returned wrong data");

  // IN enable register takes the written bits.
  a_in_mask_write: assert property (@(posedge clk) disable iff (rst)
    ce && reg_wr && (reg_addr == usb_common_pkg::OFS_IN_MASK) |=>
      (st_q.in_mask == $past(reg_wdata[2:0])))
    else $error("IN enable write lost");

  // OUT enable register takes the written bits.
  a_out_mask_write: assert property (@(posedge clk) disable iff (rst)
    ce && reg_wr && (reg_addr == usb_common_pkg::OFS_OUT_MASK) |=>
      (st_q.out_mask == $past(reg_wdata[2:1])))
    else $error("OUT enable write lost");

  // Bus event enable register takes the written bits.
  a_evt_mask_write: assert property (@(posedge clk) disable iff (rst)
    ce && reg_wr && (reg_addr == usb_common_pkg::OFS_EVT_MASK) |=>
      (st_q.evt_mask == $past(reg_wdata[3:0])))
    else $error("bus event enable write lost");

  // Frame number moves only with a start of frame.
  a_frame_hold: assert property (@(posedge clk) disable iff (rst)
    !(ce && frame_start) |=> $stable(st_q.frame))
    else $error("frame number changed without a frame start");

  // No enabled pending flag means the request drops.
  a_irq_drop: assert property (@(posedge clk) disable iff (rst)
    ce && ((in_flags & st_q.in_mask) == 3'h0) && ((out_flags[2:1] & st_q.out_mask) == 2'h0)
      && ((evt_flags & st_q.evt_mask) == 4'h0) |=> !cpu_irq)
    else $error("interrupt held with nothing enabled pending");

  c_irq_raised: cover property (@(posedge clk) disable iff (rst) $rose(cpu_irq));
  c_hs_negotiated: cover property (@(posedge clk) disable iff (rst) $rose(st_q.hs_active));
  c_addr_applied: cover property (@(posedge clk) disable iff (rst)
    st_q.pending ##1 !st_q.pending);
  c_sleep_line: cover property (@(posedge clk) disable iff (rst) $fell(sleep_line_n));
  c_wake_window: cover property (@(posedge clk) disable iff (rst)
    (wake_len_q >= 32'(WAKE_MIN)) ##1 !wake_signal_drive);
endmodule // usb_common_regs

// ===== src/usb_common_pkg.sv
// Package of offsets, field positions, reset values and timing for the USB common registers.
package usb_common_pkg;
  // Register offsets on the CPU byte port.
  localparam logic [3:0] OFS_POWER = 4'h0;
  localparam logic [3:0] OFS_ADDR = 4'h1;
  localparam logic [3:0] OFS_IN_FLAGS = 4'h2;
  localparam logic [3:0] OFS_OUT_FLAGS = 4'h3;
  localparam logic [3:0] OFS_IN_MASK = 4'h4;
  localparam logic [3:0] OFS_OUT_MASK = 4'h5;
  localparam logic [3:0] OFS_EVT_MASK = 4'h6;
  localparam logic [3:0] OFS_EVT_FLAGS = 4'h7;
  localparam logic [3:0] OFS_FRAME_HIGH = 4'h8;
  localparam logic [3:0] OFS_FRAME_LOW = 4'h9;
  // Power control field positions.
  localparam int PWR_SOFT_ATTACH = 6;
  localparam int PWR_FAST_REQ = 5;
  localparam int PWR_HS_ACTIVE = 4;
  localparam int PWR_BUS_RESET = 3;
  localparam int PWR_WAKE = 2;
  localparam int PWR_SLEEP = 1;
  localparam int PWR_SLEEP_EN = 0;
  localparam int ADDR_PENDING = 7;
  // Bus event flag positions.
  localparam int EVT_FRAME_START = 3;
  localparam int EVT_BUS_RESET = 2;
  localparam int EVT_WAKE = 1;
  localparam int EVT_SLEEP = 0;
  // Values after reset.
  localparam logic [7:0] RST_POWER = 8'h20;
  localparam logic [7:0] RST_IN_MASK = 8'h07;
  localparam logic [7:0] RST_OUT_MASK = 8'h06;
  localparam logic [7:0] RST_EVT_MASK = 8'h06;
  // Resume window that software must keep, in milliseconds, and in cycles of 4 ns.
  localparam int WAKE_MIN_MS = 10;
  localparam int WAKE_MAX_MS = 15;
  localparam int CLK_KHZ = 250000;
  localparam int WAKE_MIN_CYCLES = WAKE_MIN_MS * CLK_KHZ;
  localparam int WAKE_MAX_CYCLES = WAKE_MAX_MS * CLK_KHZ;
endpackage

// ===== src/irq_flag_bank.sv
// Sticky interrupt flags that hardware sets and a register read clears.
`timescale 1ns/1ps
module irq_flag_bank #(
  parameter int W = 3
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; state holds while low.
  input wire logic [W-1:0] set, // One-cycle event pulses.
  input wire logic clr, // Read strobe of the flag register.
  output logic [W-1:0] flags // Current pending flags.
);
  typedef struct packed {
    logic [W-1:0] flags;
  } bank_s;
  bank_s st_q, st_d;

  // Each flag is set by its event and cleared by a read; the set wins.
  generate
    for (genvar i = 0; i < W; i++) begin : g_flag
      always_comb begin
        st_d.flags[i] = set[i] | (st_q.flags[i] & ~clr);
      end
    end
  endgenerate

  // Register the state copy.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;

  a_set_wins: assert property (@(posedge clk) disable iff (rst)
    ce && (set != '0) |=> ((flags & $past(set)) == $past(set)))
    else $error("event lost against read clear");
  a_read_clears: assert property (@(posedge clk) disable iff (rst)
    ce && clr && (set == '0) |=> (flags == '0))
    else $error("flags survive a read");
endmodule // irq_flag_bank

// ===== tb/usb_link_partner.sv
// Behavioural model of the host and hub events that reach the block through the PHY.
`timescale 1ns/1ps
module usb_link_partner (
  input wire logic clk, // System clock.
  output logic bus_reset_seen, // Reset signalling level.
  output logic hs_handshake_ok, // Chirp success pulse.
  output logic sleep_detect, // Suspend pulse.
  output logic wake_detect, // Resume pulse.
  output logic frame_start, // Start-of-frame pulse.
  output logic [10:0] frame_count, // Frame number with frame_start.
  output logic transfer_end, // End of transfer pulse.
  output logic [2:0] in_done, // IN endpoint pulses.
  output logic [2:1] out_done // OUT endpoint pulses.
);
  // Everything idle at time zero; the frame number starts as a pattern, not zero.
  initial begin
    {bus_reset_seen, hs_handshake_ok, sleep_detect, wake_detect, frame_start} = 5'h00;
    {transfer_end, in_done, out_done} = 6'h00;
    frame_count = 11'h2aa;
  end
  // Raise or drop the reset level on the next edge.
  task automatic bus_reset(input logic lvl);
    @(posedge clk);
    bus_reset_seen <= lvl;
  endtask
  // One-cycle pulses; the frame number is scrambled after its strobe so stale values never match.
  task automatic ev(input logic [9:0] s, input logic [10:0] f);
    @(posedge clk);
    {hs_handshake_ok, sleep_detect, wake_detect, frame_start, transfer_end} <= s[9:5];
    {in_done, out_done} <= s[4:0];
    frame_count <= f;
    @(posedge clk);
    {hs_handshake_ok, sleep_detect, wake_detect, frame_start, transfer_end} <= 5'h00;
    {in_done, out_done} <= 5'h00;
    frame_count <= ~f;
  endtask
endmodule // usb_link_partner

// ===== tb/usb_function_common_regs_tb.sv
// Self-checking testbench for the USB common control and status registers.
`timescale 1ns/1ps
module usb_function_common_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, w, v;
  logic c;
  logic bus_reset_seen, hs_handshake_ok, sleep_detect, wake_detect, frame_start, transfer_end;
  logic line_enable, fast_negotiate_request, wake_signal_drive, sleep_line_n, cpu_irq;
  logic [10:0] frame_count, fn;
  logic [2:0] in_done, iv;
  logic [2:1] out_done;
  logic [1:0] ov;
  logic [6:0] device_bus_address;
  logic [7:0] rv [11] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h07, 8'h06, 8'h06, 8'h00, 8'h00, 8'h00,
    8'h00};
  int err_total = 0;
  int samples_checked = 0;
  // Free-running 250 MHz clock.
  initial begin
    forever #2 clk = ~clk;
  end
  usb_common_regs #(.WAKE_MIN(20), .WAKE_MAX(30)) u_dut (.clk(clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .bus_reset_seen(bus_reset_seen), .hs_handshake_ok(hs_handshake_ok),
    .sleep_detect(sleep_detect), .wake_detect(wake_detect), .frame_start(frame_start),
    .frame_count(frame_count), .transfer_end(transfer_end), .in_done(in_done),
    .out_done(out_done), .line_enable(line_enable), .fast_negotiate_request(fast_negotiate_request),
    .wake_signal_drive(wake_signal_drive), .sleep_line_n(sleep_line_n),
    .device_bus_address(device_bus_address), .cpu_irq(cpu_irq));
  usb_link_partner u_host (.clk(clk), .bus_reset_seen(bus_reset_seen),
    .hs_handshake_ok(hs_handshake_ok), .sleep_detect(sleep_detect), .wake_detect(wake_detect),
    .frame_start(frame_start), .frame_count(frame_count), .transfer_end(transfer_end),
    .in_done(in_done), .out_done(out_done));
  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle write strobe, launched on an edge so the block samples it cleanly.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read strobe; data is registered so it is checked just after the taking edge.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Wait whole cycles, then step past the edge so registered outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Expected power readback from the written value and the hardware-owned bits.
  function automatic logic [7:0] pwr(input logic [7:0] v, input logic hs, rs, sl);
    return {1'b0, v[6:5], hs, rs, v[2], sl, v[0]};
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog: the sequence needs well under 2000 cycles.
  initial begin
    #40000;
    err_total++;
    tally_and_finish();
  end
  // Main sequence of tests.
  initial begin
    void'($urandom(32'h1fad));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1 chk({3'h0, line_enable, fast_negotiate_request, wake_signal_drive, sleep_line_n, cpu_irq},
      8'h0a);
    foreach (rv[i]) rd(i[3:0], rv[i]);
    $display("test reset values done");
    // Random power writes keep the resume bit clear so software timing is honoured.
    for (int k = 0; k < 4; k++) begin
      w = 8'($urandom()) & 8'hfb;
      wr(4'h0, w);
      #1 chk({5'h0, line_enable, fast_negotiate_request, wake_signal_drive}, {5'h0, w[6:5], 1'b0});
      rd(4'h0, pwr(w, 1'b0, 1'b0, 1'b0));
    end
    ce <= 1'b0;
    wr(4'h0, ~w);
    ce <= 1'b1;
    rd(4'h0, pwr(w, 1'b0, 1'b0, 1'b0));
    // Random clock-enable gaps: a write lands only when ce was high at its edge.
    for (int k = 0; k < 4; k++) begin
      c = 1'($urandom());
      v = 8'($urandom()) & 8'hfb;
      ce <= c;
      wr(4'h0, v);
      ce <= 1'b1;
      if (c) w = v;
      rd(4'h0, pwr(w, 1'b0, 1'b0, 1'b0));
    end
    $display("test power control done");
    wr(4'h0, 8'h01);
    u_host.ev(10'h100, 11'h000);
    #1 chk({7'h0, sleep_line_n}, 8'h00);
    rd(4'h0, 8'h03);
    rd(4'h7, 8'h01);
    chk({7'h0, sleep_line_n}, 8'h01);
    wr(4'h0, 8'h00);
    u_host.ev(10'h100, 11'h000);
    #1 chk({7'h0, sleep_line_n}, 8'h01);
    rd(4'h0, 8'h02);
    wr(4'h0, 8'h04);
    #1 chk({7'h0, wake_signal_drive}, 8'h01);
    rd(4'h0, 8'h04);
    repeat (24) @(posedge clk);
    wr(4'h0, 8'h00);
    #1 chk({7'h0, wake_signal_drive}, 8'h00);
    rd(4'h7, 8'h01);
    $display("test suspend and resume done");
    wr(4'h0, 8'h20);
    u_host.bus_reset(1'b1);
    rd(4'h0, 8'h28);
    u_host.ev(10'h200, 11'h000);
    rd(4'h0, 8'h38);
    chk({7'h0, cpu_irq}, 8'h01);
    u_host.bus_reset(1'b0);
    rd(4'h0, 8'h30);
    rd(4'h7, 8'h04);
    tick(2);
    chk({7'h0, cpu_irq}, 8'h00);
    wr(4'h0, 8'h00);
    u_host.bus_reset(1'b1);
    u_host.ev(10'h200, 11'h000);
    rd(4'h0, 8'h08);
    u_host.bus_reset(1'b0);
    rd(4'h7, 8'h04);
    u_host.ev(10'h080, 11'h000);
    tick(1);
    chk({7'h0, cpu_irq}, 8'h01);
    rd(4'h7, 8'h02);
    $display("test bus reset and wake done");
    fn = 11'($urandom());
    u_host.ev(10'h040, fn);
    tick(1);
    chk({7'h0, cpu_irq}, 8'h00);
    wr(4'h9, ~fn[7:0]);
    rd(4'h8, {5'h0, fn[10:8]});
    rd(4'h9, fn[7:0]);
    wr(4'h6, 8'h0f);
    tick(1);
    chk({7'h0, cpu_irq}, 8'h01);
    rd(4'h7, 8'h08);
    wr(4'h6, 8'h06);
    $display("test frame number done");
    for (int k = 0; k < 4; k++) begin
      iv = 3'($urandom());
      ov = 2'($urandom());
      u_host.ev({5'h00, iv, ov}, 11'h000);
      tick(1);
      chk({7'h0, cpu_irq}, {7'h0, |{iv, ov}});
      rd(4'h2, {5'h0, iv});
      rd(4'h3, {5'h0, ov, 1'b0});
      rd(4'h2, 8'h00);
      rd(4'h3, 8'h00);
    end
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h00);
    u_host.ev(10'h01f, 11'h000);
    tick(2);
    chk({7'h0, cpu_irq}, 8'h00);
    rd(4'h2, 8'h07);
    rd(4'h3, 8'h06);
    $display("test endpoint flags done");
    w = {1'b0, 7'($urandom())};
    wr(4'h1, w);
    rd(4'h1, w | 8'h80);
    chk({1'b0, device_bus_address}, 8'h00);
    u_host.ev(10'h020, 11'h000);
    #1 chk({1'b0, device_bus_address}, w);
    rd(4'h1, w);
    $display("test bus address done");
    tally_and_finish();
  end
endmodule // usb_function_common_regs_tb
